/* File: rtl/sfwp_top.sv */
// serial flash write-protection and command gating with apb status
`timescale 1ns/10ps
// What this block does
// - power-up returns command engine to standby first
// - act only on whole-byte, byte-aligned commands
// - data-changing commands need write_enable_latch set
// - write-protect pin low freezes select and lock bits
// - deep power-down ignores all but release command
// - delivered state: array erased, status reads zero
// - change memory only after complete valid sequence
// - select bits and invert define protected region
// - 256KB decode with invert clear
// - invert set protects the exact complement region
// - 128KB decode with invert clear
// - ignore program or erase touching protected bytes
module sfwp_top (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_cs_n,
  input wire logic i_wp_n,
  input wire sfwp_pkg::sfwp_cmd_t i_cmd,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output sfwp_pkg::sfwp_act_t o_act,
  output logic [15:0] o_status,
  output logic o_dpd,
  output logic o_standby
);
  import sfwp_pkg::*;

  // pin synchronisers
  logic cs_m_r;
  logic cs_s_r;
  logic cs_d_r;
  logic wp_m_r;
  logic wp_s_r;

  sfwp_state_t state_r;
  sfwp_state_t state_nxt;
  logic [15:0] sr_r;
  logic [15:0] sr_nxt;
  logic [1:0] cfg_r;
  logic [15:0] rej_r;
  sfwp_act_t act_r;
  sfwp_act_t act_nxt;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      // start as selected so boot waits for a real deselect on the pin
      cs_m_r <= 1'b0;
      cs_s_r <= 1'b0;
      cs_d_r <= 1'b0;
      wp_m_r <= 1'b0;
      wp_s_r <= 1'b0;
    end else if (i_ce) begin
      cs_m_r <= i_cs_n;
      cs_s_r <= cs_m_r;
      cs_d_r <= cs_s_r;
      wp_m_r <= i_wp_n;
      wp_s_r <= wp_m_r;
    end
  end

  wire cs_rise = cs_s_r & ~cs_d_r;
  wire cs_fall = ~cs_s_r & cs_d_r;
  wire cfg_big = cfg_r[0];
  wire cfg_en = cfg_r[1];

  // protected region from the live status register
  logic prot_none;
  logic [ADDR_W-1:0] prot_lo;
  logic [ADDR_W-1:0] prot_hi;

  sfwp_region u_region (
    .i_sel(sr_r[SR_SEL_LO+4:SR_SEL_LO]),
    .i_invert(sr_r[SR_INV]),
    .i_big(cfg_big),
    .o_none(prot_none),
    .o_lo(prot_lo),
    .o_hi(prot_hi)
  );

  // command decode at deselect
  wire [7:0] opc = i_cmd.opcode;
  wire [11:0] len = i_cmd.bit_cnt;
  wire len_whole = (len[2:0] == 3'h0) & (len != 12'h000);
  wire is_ce = (opc == OP_CE_A) | (opc == OP_CE_B);
  wire is_pp = (opc == OP_PP);
  wire is_ers = (opc == OP_SE) | (opc == OP_BE32) | (opc == OP_BE64);
  wire ok_wr_en = (opc == OP_WR_EN) & (len == LEN_OPC);
  wire ok_wrdi = (opc == OP_WRDI) & (len == LEN_OPC);
  wire ok_wrsr = (opc == OP_WRSR) &
                 ((len == LEN_SR1) | (len == LEN_SR2));
  wire ok_pp = is_pp & (len >= LEN_PPMIN);
  wire ok_ers = is_ers & (len == LEN_ADR);
  wire ok_ce = is_ce & (len == LEN_OPC);
  wire ok_dpd = (opc == OP_DPD) & (len == LEN_OPC);
  wire ok_rdp = (opc == OP_RDP) & len_whole;

  // target span: protect boundaries are 4KB aligned, so whole units
  wire [18:0] max = cfg_big ? MAX_BIG : MAX_SMALL;
  wire [ADDR_W-1:0] addr = i_cmd.addr[ADDR_W-1:0] & max[ADDR_W-1:0];
  wire [ADDR_W-1:0] umask = is_pp ? MSK_PAGE :
                            (opc == OP_SE) ? MSK_4K :
                            (opc == OP_BE32) ? MSK_32K :
                            (opc == OP_BE64) ? MSK_64K :
                            max[ADDR_W-1:0];
  wire [ADDR_W-1:0] tgt_lo = is_ce ? '0 : (addr & ~umask);
  wire [ADDR_W-1:0] tgt_hi = is_ce ? max[ADDR_W-1:0] : (addr | umask);
  wire hits_prot = ~prot_none & (tgt_lo <= prot_hi) &
                   (tgt_hi >= prot_lo);
  wire wr_latch = sr_r[SR_WLATCH];
  wire data_cmd = ok_pp | ok_ers | ok_ce;
  wire data_go = len_whole & wr_latch & data_cmd &
                 ~hits_prot;

  // status write; pin low keeps the select and lock fields
  wire [15:0] wr_mask = wp_s_r ? SR_WMASK :
                        (SR_WMASK & ~SR_HWMASK);
  wire [15:0] wr_val = (len == LEN_SR2) ? i_cmd.sr_data :
                       {sr_r[15:8], i_cmd.sr_data[7:0]};
  wire [15:0] sr_written = (sr_r & ~wr_mask) | (wr_val & wr_mask);
  wire sr_go = len_whole & wr_latch & ok_wrsr;

  wire in_sel = (state_r == ST_SEL);
  wire in_dpd = (state_r == ST_DPD);
  wire eval = cs_rise & cfg_en & in_sel;
  wire wake = cs_rise & cfg_en & in_dpd & ok_rdp;
  wire accepted = eval & len_whole &
                  (ok_wr_en | ok_wrdi | ok_dpd | sr_go | data_go);
  wire rejected = ((eval | (cs_rise & in_sel & ~cfg_en)) & ~accepted) |
                  (cs_rise & in_dpd & ~wake);

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_BOOT: begin
        // wait for a clean deselect before taking any command
        if (cs_s_r & cs_d_r) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (cs_fall) begin
          state_nxt = ST_SEL;
        end
      end
      ST_SEL: begin
        if (cs_rise) begin
          state_nxt = (eval & len_whole & ok_dpd) ? ST_DPD : ST_IDLE;
        end
      end
      ST_DPD: begin
        if (wake) begin
          state_nxt = ST_IDLE;
        end
      end
    endcase
  end

  always_comb begin
    sr_nxt = sr_r;
    if (eval & len_whole) begin
      if (ok_wr_en) begin
        sr_nxt[SR_WLATCH] = 1'b1;
      end else if (ok_wrdi) begin
        sr_nxt[SR_WLATCH] = 1'b0;
      end else if (sr_go) begin
        sr_nxt = sr_written;
        sr_nxt[SR_WLATCH] = 1'b0;
      end else if (data_go) begin
        sr_nxt[SR_WLATCH] = 1'b0;
      end
    end
  end

  always_comb begin
    act_nxt = '0;
    act_nxt.valid = eval & data_go;
    act_nxt.erase = ~is_pp;
    act_nxt.lo = tgt_lo;
    act_nxt.hi = tgt_hi;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_r <= ST_BOOT;
      sr_r <= SR_RST;
      act_r <= '0;
    end else if (i_ce) begin
      state_r <= state_nxt;
      sr_r <= sr_nxt;
      act_r <= act_nxt;
    end
  end

  // apb slave: one wait state, registered answer
  wire apb_acc = i_psel & i_penable;
  wire a_stat = (i_paddr == A_STAT);
  wire a_cfg = (i_paddr == A_CFG);
  wire a_rlo = (i_paddr == A_RLO);
  wire a_rhi = (i_paddr == A_RHI);
  wire a_rej = (i_paddr == A_REJ);
  wire a_hit = a_stat | a_cfg | a_rlo | a_rhi | a_rej;
  wire [31:0] rd_stat = {14'h0000, o_standby, in_dpd, sr_r};
  wire [31:0] rd_rlo = {{(32-ADDR_W){1'b0}}, prot_lo};
  wire [31:0] rd_rhi = {prot_none, {(31-ADDR_W){1'b0}}, prot_hi};
  wire [31:0] rd_mux = a_stat ? rd_stat :
                       a_cfg ? {30'h00000000, cfg_r} :
                       a_rlo ? rd_rlo :
                       a_rhi ? rd_rhi :
                       a_rej ? {16'h0000, rej_r} : 32'h00000000;
  wire apb_done = apb_acc & pready_r;
  wire cfg_wr = apb_done & i_pwrite & a_cfg;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end else if (i_ce) begin
      pready_r <= apb_acc & ~pready_r;
      if (apb_acc & ~pready_r) begin
        pslverr_r <= ~a_hit;
        prdata_r <= i_pwrite ? 32'h00000000 : rd_mux;
      end else begin
        pslverr_r <= 1'b0;
        prdata_r <= 32'h00000000;
      end
    end
  end

  // config writes land only on the completing edge
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cfg_r <= CFG_RST;
    end else if (i_ce & cfg_wr) begin
      cfg_r <= i_pwdata[1:0];
    end
  end

  // saturating so software sees a ceiling, not a wrapped count
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rej_r <= 16'h0000;
    end else if (i_ce & rejected & (rej_r != REJ_MAX)) begin
      rej_r <= rej_r + 16'h0001;
    end
  end

  logic standby_r;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      standby_r <= 1'b0;
    end else if (i_ce) begin
      standby_r <= (state_nxt == ST_IDLE);
    end
  end

  logic dpd_r;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      dpd_r <= 1'b0;
    end else if (i_ce) begin
      dpd_r <= (state_nxt == ST_DPD);
    end
  end

  assign o_prdata = prdata_r;
  assign o_pready = pready_r;
  assign o_pslverr = pslverr_r;
  assign o_act = act_r;
  assign o_status = sr_r;
  assign o_dpd = dpd_r;
  assign o_standby = standby_r;
endmodule

/* File: pkg/sfwp_pkg.sv */
// constants and carrier types for the flash write-protection block
package sfwp_pkg;
  localparam int ADDR_W = 18;
  // command opcodes of the front end
  localparam logic [7:0] OP_WR_EN = 8'h06;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_WRSR = 8'h01;
  localparam logic [7:0] OP_PP = 8'h02;
  localparam logic [7:0] OP_SE = 8'h20;
  localparam logic [7:0] OP_BE32 = 8'h52;
  localparam logic [7:0] OP_BE64 = 8'hD8;
  localparam logic [7:0] OP_CE_A = 8'hC7;
  localparam logic [7:0] OP_CE_B = 8'h60;
  localparam logic [7:0] OP_DPD = 8'hB9;
  localparam logic [7:0] OP_RDP = 8'hAB;
  // command lengths in bits
  localparam logic [11:0] LEN_OPC = 12'h008;
  localparam logic [11:0] LEN_SR1 = 12'h010;
  localparam logic [11:0] LEN_SR2 = 12'h018;
  localparam logic [11:0] LEN_ADR = 12'h020;
  localparam logic [11:0] LEN_PPMIN = 12'h028;
  // status register layout
  localparam int SR_WLATCH = 1;
  localparam int SR_SEL_LO = 2;
  localparam int SR_INV = 14;
  localparam logic [15:0] SR_RST = 16'h0000;
  localparam logic [15:0] SR_WMASK = 16'h41FC;
  localparam logic [15:0] SR_HWMASK = 16'h01FC;
  // address spans
  localparam logic [18:0] MAX_BIG = 19'h3FFFF;
  localparam logic [18:0] MAX_SMALL = 19'h1FFFF;
  localparam logic [18:0] SZ_4K = 19'h01000;
  localparam logic [18:0] SZ_8K = 19'h02000;
  localparam logic [18:0] SZ_16K = 19'h04000;
  localparam logic [18:0] SZ_32K = 19'h08000;
  localparam logic [18:0] SZ_64K = 19'h10000;
  localparam logic [18:0] SZ_128K = 19'h20000;
  localparam logic [17:0] MSK_PAGE = 18'h000FF;
  localparam logic [17:0] MSK_4K = 18'h00FFF;
  localparam logic [17:0] MSK_32K = 18'h07FFF;
  localparam logic [17:0] MSK_64K = 18'h0FFFF;
  // apb register map (byte addresses)
  localparam logic [7:0] A_STAT = 8'h00;
  localparam logic [7:0] A_CFG = 8'h04;
  localparam logic [7:0] A_RLO = 8'h08;
  localparam logic [7:0] A_RHI = 8'h0C;
  localparam logic [7:0] A_REJ = 8'h10;
  localparam logic [1:0] CFG_RST = 2'h3;
  localparam logic [15:0] REJ_MAX = 16'hFFFF;

  typedef struct packed {
    logic [7:0] opcode;
    logic [23:0] addr;
    logic [15:0] sr_data;
    logic [11:0] bit_cnt;
  } sfwp_cmd_t;

  typedef struct packed {
    logic valid;
    logic erase;
    logic [ADDR_W-1:0] lo;
    logic [ADDR_W-1:0] hi;
  } sfwp_act_t;

  typedef enum logic [3:0] {
    ST_BOOT = 4'b0001,
    ST_IDLE = 4'b0010,
    ST_SEL = 4'b0100,
    ST_DPD = 4'b1000
  } sfwp_state_t;
endpackage

/* File: rtl/sfwp_region.sv */
// protected address region decode from select bits and invert
`timescale 1ns/10ps
module sfwp_region (
  input wire logic [4:0] i_sel,
  input wire logic i_invert,
  input wire logic i_big,
  output logic o_none,
  output logic [sfwp_pkg::ADDR_W-1:0] o_lo,
  output logic [sfwp_pkg::ADDR_W-1:0] o_hi
);
  import sfwp_pkg::*;
  wire [2:0] sub = i_sel[2:0];
  wire [1:0] blk = i_sel[1:0];
  wire bottom = i_sel[3];
  wire [18:0] max = i_big ? MAX_BIG : MAX_SMALL;
  wire sub_32k = (sub == 3'h4) | (sub == 3'h5) | (sub == 3'h6);
  wire [18:0] size_sec = (sub == 3'h1) ? SZ_4K :
                         (sub == 3'h2) ? SZ_8K :
                         (sub == 3'h3) ? SZ_16K :
                         sub_32k ? SZ_32K : 19'h00000;
  wire [18:0] size = i_sel[4] ? size_sec :
                     ((blk == 2'h1) ? SZ_64K : SZ_128K);
  // small part: any sel[1] set in block mode covers the whole array
  wire all_base = i_sel[4] ? (sub == 3'h7) :
                  ((blk == 2'h3) | (blk[1] & ~i_big));
  wire none_base = i_sel[4] ? (sub == 3'h0) : (blk == 2'h0);
  wire [18:0] top_lo = max + 19'h00001 - size;
  wire [18:0] base_lo = (all_base | bottom) ? 19'h00000 : top_lo;
  wire [18:0] base_hi = all_base ? max :
                        (bottom ? size - 19'h00001 : max);
  // regions always touch one end, so the complement is one span
  wire [18:0] inv_lo = bottom ? base_hi + 19'h00001 : 19'h00000;
  wire [18:0] inv_hi = bottom ? max : base_lo - 19'h00001;
  wire all_eff = i_invert ? none_base : all_base;
  wire [18:0] lo_eff = all_eff ? 19'h00000 :
                       (i_invert ? inv_lo : base_lo);
  wire [18:0] hi_eff = all_eff ? max :
                       (i_invert ? inv_hi : base_hi);

  assign o_none = i_invert ? all_base : none_base;
  assign o_lo = lo_eff[ADDR_W-1:0];
  assign o_hi = hi_eff[ADDR_W-1:0];
endmodule

/* File: sim/sfwp_props.sv */
// assertion checker for the write-protection block
`timescale 1ns/10ps
module sfwp_props
  import sfwp_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_cs_n,
  input wire logic i_wp_n,
  input wire sfwp_pkg::sfwp_cmd_t i_cmd,
  input wire sfwp_pkg::sfwp_act_t o_act,
  input wire logic [15:0] o_status,
  input wire logic o_dpd,
  input wire logic o_standby
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  sequence s_rise;
    !i_cs_n ##1 i_cs_n;
  endsequence
  sequence s_pulse;
    o_act.valid ##1 !o_act.valid;
  endsequence
  property p_rst;
    $fell(i_rst) |-> o_status == 16'h0000 && !o_dpd && !o_standby;
  endproperty
  property p_gap;
    s_rise |-> (!o_act.valid) [*3];
  endproperty
  property p_one;
    o_act.valid |-> s_pulse;
  endproperty
  property p_src;
    o_act.valid |-> $past(i_cs_n, 3) && !$past(i_cs_n, 4);
  endproperty
  property p_latch;
    o_act.valid |-> $past(o_status[1]) && !o_status[1];
  endproperty
  property p_len;
    o_act.valid |-> $past(i_cmd.bit_cnt[2:0]) == 3'h0;
  endproperty
  property p_dpd;
    o_dpd |-> !o_act.valid && !$rose(o_status[1]);
  endproperty
  // window covers the pin synchroniser and the eval stage
  property p_wp;
    (!i_wp_n) [*4] |=> $stable(o_status[8:2]);
  endproperty
  a_rst: assert property (p_rst)
    else $error("bad state after reset");
  a_gap: assert property (p_gap)
    else $error("change before select release settled");
  a_one: assert property (p_one)
    else $error("change order longer than one cycle");
  a_src: assert property (p_src)
    else $error("change not tied to select release");
  a_latch: assert property (p_latch)
    else $error("change without write enable");
  a_len: assert property (p_len)
    else $error("change after partial byte");
  a_dpd: assert property (p_dpd)
    else $error("command acted on in power-down");
  a_wp: assert property (p_wp)
    else $error("protect bits moved with pin low");
endmodule
bind sfwp_top sfwp_props sfwp_props_i (
  .i_clk(i_clk), .i_rst(i_rst), .i_cs_n(i_cs_n), .i_wp_n(i_wp_n),
  .i_cmd(i_cmd), .o_act(o_act), .o_status(o_status), .o_dpd(o_dpd),
  .o_standby(o_standby)
);

/* File: sim/sfwp_host.sv */
// host model issuing whole commands on select and command lines
`timescale 1ns/10ps
module sfwp_host
  import sfwp_pkg::*;
(
  input wire logic i_clk,
  output logic o_cs_n,
  output sfwp_pkg::sfwp_cmd_t o_cmd
);
  initial begin
    o_cs_n = 1'b1;
    o_cmd = '0;
  end
  task automatic send(input logic [7:0] op, input logic [23:0] a,
                      input logic [15:0] sr, input logic [11:0] n);
    @(posedge i_clk);
    o_cs_n <= 1'b0;
    repeat (3) @(posedge i_clk);
    o_cmd <= {op, a, sr, n};
    o_cs_n <= 1'b1;
    repeat (6) @(posedge i_clk);
    // held time over: no stale command left on the lines
    o_cmd <= ~o_cmd;
  endtask
endmodule

/* File: sim/sfwp_top_bench.sv */
// self-checking bench for the write-protection block
`timescale 1ns/10ps
module sfwp_top_bench;
  import sfwp_pkg::*;
  logic clk = 1'b0, rst = 1'b1, wp_n = 1'b1, ce = 1'b1, cs_n;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, rdy, err, dpd, stby, re;
  logic [7:0] padr = 8'h00;
  logic [31:0] pwd = 32'h0, prd, rd;
  logic [15:0] st;
  sfwp_cmd_t cmd;
  sfwp_act_t act, lact;
  int error_cnt = 0, checks_done = 0, nact = 0;
  logic [15:0] srv [7] = '{16'h0004, 16'h0064, 16'h0050, 16'h4044,
                           16'h0004, 16'h0008, 16'h005C};
  logic [1:0] cfv [7] = '{2'h3, 2'h3, 2'h3, 2'h3, 2'h2, 2'h2, 2'h2};
  logic [17:0] lov [7] = '{18'h30000, 18'h0, 18'h38000, 18'h0,
                           18'h10000, 18'h0, 18'h0};
  logic [17:0] hiv [7] = '{18'h3FFFF, 18'h00FFF, 18'h3FFFF, 18'h3EFFF,
                           18'h1FFFF, 18'h1FFFF, 18'h1FFFF};
  always #5 clk = ~clk;
  sfwp_top sfwp_top_i (.i_clk(clk), .i_rst(rst), .i_ce(ce),
    .i_cs_n(cs_n), .i_wp_n(wp_n), .i_cmd(cmd), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(padr), .i_pwdata(pwd),
    .o_prdata(prd), .o_pready(rdy), .o_pslverr(err), .o_act(act),
    .o_status(st), .o_dpd(dpd), .o_standby(stby));
  sfwp_host sfwp_host_i (.i_clk(clk), .o_cs_n(cs_n), .o_cmd(cmd));
  always @(posedge clk) if (act.valid === 1'b1) begin
    nact++;
    lact = act;
  end
  task chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR %0t seen %h want %h", $time, s, e);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    padr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (rdy !== 1'b1 && n < 16);
    if (rdy !== 1'b1) begin
      error_cnt++;
      $display("ERROR %0t no apb answer", $time);
    end
    rd = prd;
    re = err;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task set_latch;
    sfwp_host_i.send(OP_WR_EN, 24'h0, 16'h0, LEN_OPC);
  endtask
  task wrsr(input logic [15:0] v);
    set_latch;
    sfwp_host_i.send(OP_WRSR, 24'h0, v, LEN_SR2);
  endtask
  task t_reset;
    chk(st, 16'h0000);
    chk(stby, 1'b1);
    apb(1'b0, A_STAT, 32'h0);
    chk(rd, 32'h00020000);
    apb(1'b0, A_CFG, 32'h0);
    chk(rd, 32'h00000003);
    apb(1'b1, 8'h40, 32'h1);
    chk(re, 1'b1);
    $display("t_reset done");
  endtask
  task t_wel;
    sfwp_host_i.send(OP_PP, 24'h012345, 16'h0, LEN_PPMIN);
    chk(nact, 0);
    set_latch;
    chk(st[1], 1'b1);
    // one bit past a byte boundary must be dropped whole
    sfwp_host_i.send(OP_PP, 24'h012345, 16'h0, 12'h029);
    chk(nact, 0);
    sfwp_host_i.send(OP_PP, 24'h012345, 16'h0, LEN_PPMIN);
    chk(nact, 1);
    chk({lact.erase, lact.lo}, 19'h12300);
    chk(lact.hi, 18'h123FF);
    chk(st[1], 1'b0);
    $display("t_wel done");
  endtask
  task t_prot;
    for (int i = 0; i < 7; i++) begin
      apb(1'b1, A_CFG, {30'h0, cfv[i]});
      wrsr(srv[i]);
      chk(st, srv[i]);
      apb(1'b0, A_RLO, 32'h0);
      chk(rd, {14'h0, lov[i]});
      apb(1'b0, A_RHI, 32'h0);
      chk(rd, {14'h0, hiv[i]});
    end
    apb(1'b1, A_CFG, 32'h3);
    wrsr(16'h0004);
    set_latch;
    sfwp_host_i.send(OP_SE, 24'h03F000, 16'h0, LEN_ADR);
    chk(nact, 1);
    sfwp_host_i.send(OP_SE, 24'h000000, 16'h0, LEN_ADR);
    chk(nact, 2);
    chk({lact.erase, lact.lo, lact.hi[11:0]}, 31'h40000FFF);
    wrsr(16'h0000);
    apb(1'b0, A_RHI, 32'h0);
    chk(rd[31], 1'b1);
    $display("t_prot done");
  endtask
  task t_wp;
    @(posedge clk);
    wp_n <= 1'b0;
    wrsr(16'h4010);
    chk(st, 16'h4000);
    @(posedge clk);
    wp_n <= 1'b1;
    $display("t_wp done");
  endtask
  task t_dpd;
    sfwp_host_i.send(OP_DPD, 24'h0, 16'h0, LEN_OPC);
    chk(dpd, 1'b1);
    set_latch;
    chk(st, 16'h4000);
    sfwp_host_i.send(OP_RDP, 24'h0, 16'h0, LEN_OPC);
    chk(dpd, 1'b0);
    $display("t_dpd done");
  endtask
  // command enable off, then clock enable low: neither may act
  task t_gate;
    apb(1'b1, A_CFG, 32'h1);
    set_latch;
    chk(st, 16'h4000);
    apb(1'b1, A_CFG, 32'h3);
    @(posedge clk);
    ce <= 1'b0;
    set_latch;
    @(posedge clk);
    ce <= 1'b1;
    repeat (6) @(posedge clk);
    chk(st, 16'h4000);
    // refused so far: two in t_wel, one in t_prot, t_dpd, t_gate
    apb(1'b0, A_REJ, 32'h0);
    chk(rd, 32'h00000005);
    $display("t_gate done");
  endtask
  task report_and_stop;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (7000) @(posedge clk);
    t_reset;
    t_wel;
    t_prot;
    t_wp;
    t_dpd;
    t_gate;
    report_and_stop;
  end
  initial begin
    #200000;
    error_cnt++;
    report_and_stop;
  end
endmodule
